// ==== core/dbp_display_backend.v ====
// Display backend: field selection, peaking, CTI, delays, oversampling and output sync.
//
// Summary of operation
// RQ1: Mode 11 shows previous then current B, beta.
// RQ2: Modes 00 AABB, 01 A alpha, 10 A alpha-beta.
// RQ3: Hold command freezes the displayed field choice.
// RQ4: Chroma line shift moves chroma one line up.
// RQ5: Gain codes map to quarter steps, 2.5/3/4.
// RQ6: Peaking is HP minus BP plus delayed input.
// RQ7: One shared coring stage, with bypass bit.
// RQ8: Peaking runs on the display clock.
// RQ9: Chroma correction scales slope by boost amplitude.
// RQ10: Transition found at lowpassed second-derivative zero crossing.
// RQ11: Larger threshold limits sharpening to big transitions.
// RQ12: Sharpened chroma clamped to local neighbour range.
// RQ13: Luma delayed minus eight to seven pixels.
// RQ14: Fine delay shifts luma one oversample period.
// RQ15: Two oversampled 8:8:8 samples per display pixel.
// RQ16: Luma ninth bit headroom; chroma full-scale option.
// RQ17: Line length is four times quarter count.
// RQ18: Active width sixteen times count, lead positions.
// RQ19: Free-run field twice half count; locked follows input.
// RQ20: Active and inactive line counts mark vertical regions.
// RQ21: Controller uses only 00, 10, 11 sync modes; the code accepts every HFR/VFR combination.
// RQ22: Soft lock pulls free-run vsync to input phase.
// RQ23: Lost input forces selected free-running modes.
// RQ24: Hsync 64 clocks, polarity, free-run or locked.
// RQ25: Vsync two lines, delayed, two per input field.
// RQ26: Coarse delay is 4-bit two's complement.
// RQ27: Timing changes take effect at field boundary.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`include "dbp_defs.vh"
module dbp_display_backend #(
   parameter LINE_MAX = 2048
) (
   input wire aclk, // display clock
   input wire aresetn, // synchronous reset, active low
   input wire [7:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // byte enables
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output wire [1:0] s_axi_bresp, // write response
   output wire s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [7:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output wire [31:0] s_axi_rdata, // read data
   output wire [1:0] s_axi_rresp, // read response
   output wire s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   input wire [7:0] pix_y_in, // luma from field memory
   input wire [7:0] pix_u_in, // chroma U, two's complement
   input wire [7:0] pix_v_in, // chroma V, two's complement
   input wire hsync_in, // composite-derived hsync pin
   input wire vsync_in, // composite-derived vsync pin
   input wire signal_lost, // composite input absent or weak pin
   output wire horiz_sync_out, // horizontal sync
   output wire vert_sync_out, // vertical sync
   output wire h_active, // horizontal active area
   output wire v_active, // vertical active area
   output wire rd_field_b, // memory read selects field B
   output wire rd_prev_field, // memory read selects previous field
   output wire raster_beta, // display raster beta
   output wire rd_freeze, // memory write frozen
   output wire [8:0] dac_y0, // luma, first oversample
   output wire [8:0] dac_y1, // luma, second oversample
   output wire [8:0] dac_u0, // U, first oversample
   output wire [8:0] dac_u1, // U, second oversample
   output wire [8:0] dac_v0, // V, first oversample
   output wire [8:0] dac_v1 // V, second oversample
);
   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   reg [31:0] ctrl_r, peak_r, htim_r, vtim_r, vmsc_r, st_r;
   reg awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   reg aw_full_r, w_full_r;
   reg [7:0] awaddr_r;
   reg [31:0] wdata_r, rdata_r;
   reg [3:0] wstrb_r;
   reg [1:0] bresp_r, rresp_r;
   reg [31:0] rd_nxt;
   reg [1:0] rresp_nxt;
   integer k, j;
   wire do_wr = aw_full_r && w_full_r && !bvalid_r;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] be;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               merge[b*8 +: 8] = nw[b*8 +: 8];
            end
         end
      end
   endfunction

   always @* begin
      rresp_nxt = `DBP_RESP_OK;
      if (s_axi_araddr[4:0] == `DBP_OFF_CTRL && s_axi_araddr[7:5] == 3'h0) begin
         rd_nxt = ctrl_r;
      end else if (s_axi_araddr[4:0] == `DBP_OFF_PEAK && s_axi_araddr[7:5] == 3'h0) begin
         rd_nxt = peak_r;
      end else if (s_axi_araddr[4:0] == `DBP_OFF_HTIM && s_axi_araddr[7:5] == 3'h0) begin
         rd_nxt = htim_r;
      end else if (s_axi_araddr[4:0] == `DBP_OFF_VTIM && s_axi_araddr[7:5] == 3'h0) begin
         rd_nxt = vtim_r;
      end else if (s_axi_araddr[4:0] == `DBP_OFF_VMSC && s_axi_araddr[7:5] == 3'h0) begin
         rd_nxt = vmsc_r;
      end else if (s_axi_araddr[4:0] == `DBP_OFF_STAT && s_axi_araddr[7:5] == 3'h0) begin
         rd_nxt = st_r;
      end else begin
         rd_nxt = 32'h00000000;
         rresp_nxt = `DBP_RESP_DEC;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `DBP_CTRL_RST;
         peak_r <= `DBP_PEAK_RST;
         htim_r <= `DBP_HTIM_RST;
         vtim_r <= `DBP_VTIM_RST;
         vmsc_r <= `DBP_VMSC_RST;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         arready_r <= 1'b1;
         bvalid_r <= 1'b0;
         rvalid_r <= 1'b0;
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bresp_r <= `DBP_RESP_OK;
         rresp_r <= `DBP_RESP_OK;
         rdata_r <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awaddr_r <= s_axi_awaddr;
            aw_full_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (s_axi_wvalid && wready_r) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_full_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (do_wr) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= `DBP_RESP_OK;
            if (awaddr_r[7:5] != 3'h0) begin
               bresp_r <= `DBP_RESP_DEC;
            end else if (awaddr_r[4:0] == `DBP_OFF_CTRL) begin
               ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
            end else if (awaddr_r[4:0] == `DBP_OFF_PEAK) begin
               peak_r <= merge(peak_r, wdata_r, wstrb_r);
            end else if (awaddr_r[4:0] == `DBP_OFF_HTIM) begin
               htim_r <= merge(htim_r, wdata_r, wstrb_r);
            end else if (awaddr_r[4:0] == `DBP_OFF_VTIM) begin
               vtim_r <= merge(vtim_r, wdata_r, wstrb_r);
            end else if (awaddr_r[4:0] == `DBP_OFF_VMSC) begin
               vmsc_r <= merge(vmsc_r, wdata_r, wstrb_r);
            end else if (awaddr_r[4:0] != `DBP_OFF_STAT) begin
               bresp_r <= `DBP_RESP_DEC;
            end
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
         if (s_axi_arvalid && arready_r) begin
            rdata_r <= rd_nxt;
            rresp_r <= rresp_nxt;
            rvalid_r <= 1'b1;
            arready_r <= 1'b0;
         end
         if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers: a change counts when stages two and three agree.
   // ---------------------------------------------------------------
   wire [2:0] pins = {signal_lost, vsync_in, hsync_in};
   wire [2:0] flt;
   reg [2:0] flt_d;
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_sync
         reg s1, s2, s3, f;
         always @(posedge aclk) begin
            if (!aresetn) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               f <= 1'b0;
            end else begin
               s1 <= pins[g];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) begin
                  f <= s3;
               end
            end
         end
         assign flt[g] = f;
      end
   endgenerate
   wire h_rise = flt[0] && !flt_d[0];
   wire v_rise = flt[1] && !flt_d[1];
   wire h_fr = ctrl_r[`DBP_F_HFR] | (flt[2] & ctrl_r[9]); // [RQ23] [RQ24]
   wire v_fr = ctrl_r[`DBP_F_VFR] | (flt[2] & ctrl_r[10]); // [RQ23] [RQ19]

   // ---------------------------------------------------------------
   // Output sync controller
   // ---------------------------------------------------------------
   reg [10:0] hcnt_r, vcnt_r, llen_r, lead_r, hact_r, in_lines_r, meas_half_r;
   reg [10:0] flen_r, alin_r, ilin_r;
   reg [3:0] pend_r;
   reg pend_on_r, hs_r, vs_r, ha_r, va_r;
   reg [1:0] phase_r;
   reg fb_r, prev_r, beta_r, frz_r;
   wire line_end = (!h_fr && h_rise) || (hcnt_r == llen_r - 11'h001); // [RQ24]
   wire pend_fire = line_end && pend_on_r && pend_r == 4'h0;
   wire wrap = vcnt_r >= flen_r - 11'h001;
   wire field_bnd = line_end && ((pend_fire && !v_fr) || (!pend_fire && wrap));
   wire [10:0] vnxt = field_bnd ? 11'h000 :
                      pend_fire ? {1'b0, vmsc_r[`DBP_F_SOFF]} : vcnt_r + 11'h001; // [RQ22]
   wire [1:0] ph_n = phase_r + 2'h1;

   always @(posedge aclk) begin
      if (!aresetn) begin
         flt_d <= 3'h0;
         hcnt_r <= 11'h000;
         vcnt_r <= 11'h000;
         llen_r <= 11'h480;
         lead_r <= 11'h060;
         hact_r <= 11'h3C0;
         flen_r <= 11'h270;
         alin_r <= 11'h120;
         ilin_r <= 11'h016;
         in_lines_r <= 11'h000;
         meas_half_r <= 11'h138;
         pend_r <= 4'h0;
         pend_on_r <= 1'b0;
         hs_r <= 1'b0;
         vs_r <= 1'b0;
         ha_r <= 1'b0;
         va_r <= 1'b0;
         phase_r <= 2'h0;
         fb_r <= 1'b0;
         prev_r <= 1'b0;
         beta_r <= 1'b0;
         frz_r <= 1'b0;
         st_r <= 32'h00000000;
      end else begin
         flt_d <= flt;
         hcnt_r <= line_end ? 11'h000 : hcnt_r + 11'h001;
         if (v_rise) begin
            meas_half_r <= {1'b0, in_lines_r[10:1]}; // [RQ25]
            in_lines_r <= 11'h000;
            if (!v_fr || ctrl_r[`DBP_F_SOFT]) begin
               pend_r <= vmsc_r[`DBP_F_ODEL]; // [RQ25] [RQ22]
               pend_on_r <= 1'b1;
            end
         end else if (line_end) begin
            in_lines_r <= in_lines_r + 11'h001;
            if (pend_fire) begin
               pend_on_r <= 1'b0;
            end else if (pend_on_r) begin
               pend_r <= pend_r - 4'h1;
            end
         end
         if (line_end) begin
            vcnt_r <= vnxt;
         end
         if (field_bnd) begin
            llen_r <= {htim_r[`DBP_F_PPLQ], 2'b00}; // [RQ17] [RQ27]
            hact_r <= {1'b0, htim_r[`DBP_F_APD16], 4'h0}; // [RQ18] [RQ27]
            lead_r <= htim_r[`DBP_F_LEAD];
            flen_r <= v_fr ? {vtim_r[`DBP_F_LPFH], 1'b0} : meas_half_r; // [RQ19] [RQ25]
            alin_r <= {1'b0, vtim_r[`DBP_F_ALINES]}; // [RQ20]
            ilin_r <= {1'b0, vtim_r[`DBP_F_ILINES]};
            phase_r <= ph_n;
            frz_r <= ctrl_r[`DBP_F_HOLD]; // [RQ3]
            if (!ctrl_r[`DBP_F_HOLD]) begin
               case (ctrl_r[`DBP_F_SCS]) // [RQ2] [RQ1]
                  2'h0: begin
                     fb_r <= ph_n[1];
                     prev_r <= 1'b0;
                     beta_r <= ph_n[1];
                  end
                  2'h1: begin
                     fb_r <= 1'b0;
                     prev_r <= 1'b0;
                     beta_r <= 1'b0;
                  end
                  2'h2: begin
                     fb_r <= 1'b0;
                     prev_r <= 1'b0;
                     beta_r <= ph_n[0];
                  end
                  default: begin
                     fb_r <= 1'b1;
                     prev_r <= !ph_n[1];
                     beta_r <= 1'b1;
                  end
               endcase
            end
         end
         hs_r <= (hcnt_r < `DBP_HSYNC_LEN) ^ ctrl_r[`DBP_F_HPOL]; // [RQ24]
         vs_r <= (vcnt_r < `DBP_VSYNC_LINES) ^ ctrl_r[`DBP_F_VPOL]; // [RQ25]
         ha_r <= hcnt_r >= lead_r && hcnt_r < lead_r + hact_r; // [RQ18]
         va_r <= vcnt_r >= ilin_r && vcnt_r < ilin_r + alin_r; // [RQ20]
         st_r <= {19'h00000, pend_on_r, flt[2], v_fr, h_fr, phase_r, 7'h00};
      end
   end

   // ---------------------------------------------------------------
   // Chroma line shift: luma passes a line store so chroma leads by one line.
   // ---------------------------------------------------------------
   reg [7:0] lmem [0:LINE_MAX-1];
   reg [7:0] lq_r, yd_r;
   always @(posedge aclk) begin
      lq_r <= lmem[hcnt_r];
      lmem[hcnt_r] <= pix_y_in;
      yd_r <= pix_y_in;
   end
   wire [7:0] ysel = ctrl_r[`DBP_F_CSHIFT] ? lq_r : yd_r; // [RQ4]

   // ---------------------------------------------------------------
   // Luma peaking on the display clock.
   // ---------------------------------------------------------------
   function signed [5:0] gq; // gain in quarter units
      input [3:0] c;
      begin
         if (c <= 4'hC) begin
            gq = $signed({2'b00, c}) - 6'sh04; // [RQ5]
         end else if (c == 4'hD) begin
            gq = 6'sh0A;
         end else if (c == 4'hE) begin
            gq = 6'sh0C;
         end else begin
            gq = 6'sh10;
         end
      end
   endfunction
   reg [7:0] tp [0:4];
   reg [8:0] yp_r;
   wire signed [12:0] t0 = {5'h00, tp[0]};
   wire signed [12:0] t1 = {5'h00, tp[1]};
   wire signed [12:0] t2 = {5'h00, tp[2]};
   wire signed [12:0] t3 = {5'h00, tp[3]};
   wire signed [12:0] t4 = {5'h00, tp[4]};
   wire signed [12:0] hp = t0 + t4 - ((t1 + t3) <<< 2) + (t2 <<< 2) + (t2 <<< 1); // [RQ6]
   wire signed [12:0] bp = t0 + t4 - (t2 <<< 1); // [RQ6]
   wire signed [5:0] gh = gq(peak_r[`DBP_F_HPG]);
   wire signed [5:0] gb = gq(peak_r[`DBP_F_BPG]);
   wire signed [19:0] ph = gh * hp;
   wire signed [19:0] pb = (gb * bp) <<< 1;
   wire signed [19:0] pks = (ph - pb) >>> 6; // [RQ6]
   wire signed [12:0] pk = pks[12:0];
   wire core0 = !ctrl_r[`DBP_F_CORBYP] && pk > -$signed(`DBP_CORE_THR)
                && pk < $signed(`DBP_CORE_THR); // [RQ7]
   wire signed [12:0] ysum = t2 + 13'sh0080 + (core0 ? 13'sh0000 : pk); // [RQ16]
   always @(posedge aclk) begin // [RQ8]
      for (k = 4; k > 0; k = k - 1) begin
         tp[k] <= tp[k-1];
      end
      tp[0] <= ysel;
      yp_r <= ysum < 0 ? 9'h000 : (ysum > 13'sh01FF ? 9'h1FF : ysum[8:0]);
   end

   // ---------------------------------------------------------------
   // Coarse and fine luma delay, 2x oversampling.
   // ---------------------------------------------------------------
   reg [8:0] ydl [0:15];
   reg [8:0] yc_r, yp1_r, y0_r, y1_r;
   wire [3:0] cd = peak_r[`DBP_F_CDEL];
   wire [9:0] ymid = {1'b0, yc_r} + {1'b0, yp1_r};
   always @(posedge aclk) begin
      for (j = 15; j > 0; j = j - 1) begin
         ydl[j] <= ydl[j-1];
      end
      ydl[0] <= yp_r;
      yc_r <= ydl[{~cd[3], cd[2:0]}]; // [RQ13] [RQ26]
      yp1_r <= yc_r;
      if (ctrl_r[`DBP_F_FINE]) begin // [RQ14]
         y0_r <= ymid[9:1];
         y1_r <= yc_r;
      end else begin // [RQ15]
         y0_r <= yc_r;
         y1_r <= ymid[9:1];
      end
   end

   // ---------------------------------------------------------------
   // Chroma transition sharpener, per component.
   // ---------------------------------------------------------------
   wire [23:0] d2all;
   wire [21:0] smag;
   wire [17:0] co0, co1;
   reg [1:0] zwin_r;
   wire signed [11:0] d2u = d2all[11:0];
   wire signed [11:0] d2v = d2all[23:12];
   wire signed [12:0] dsum = d2u + d2v;
   reg dsneg_r;
   wire [11:0] smsum = {1'b0, smag[10:0]} + {1'b0, smag[21:11]};
   wire cti_on = zwin_r != 2'h0 && smsum > {4'h0, peak_r[`DBP_F_THR]}; // [RQ11]
   always @(posedge aclk) begin
      dsneg_r <= dsum[12];
      zwin_r <= (dsum[12] != dsneg_r) ? 2'h3 : (zwin_r == 2'h0 ? 2'h0 : zwin_r - 2'h1); // [RQ10]
   end
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_cti
         reg signed [7:0] cs [0:4];
         reg signed [10:0] l0, l1, l2;
         reg signed [7:0] cq, cdl [0:7];
         reg [8:0] o0, o1;
         integer n;
         wire signed [10:0] lp = cs[0] + (cs[1] <<< 1) + cs[2];
         wire signed [11:0] d2 = l0 - (l1 <<< 1) + l2; // [RQ10]
         wire signed [11:0] sl = l0 - l2;
         wire [10:0] sa = sl[11] ? -sl[10:0] : sl[10:0];
         wire [14:0] prod = sa * peak_r[`DBP_F_BOOST];
         wire signed [11:0] m = {1'b0, prod[14:4]};
         wire signed [11:0] c3 = cs[3];
         wire signed [11:0] cr = c3 + (cti_on ? (d2[11] ? m : -m) : 12'sh000); // [RQ9]
         wire signed [7:0] mx1 = cs[2] > cs[3] ? cs[2] : cs[3];
         wire signed [7:0] mn1 = cs[2] < cs[3] ? cs[2] : cs[3];
         wire signed [7:0] mx = mx1 > cs[4] ? mx1 : cs[4];
         wire signed [7:0] mn = mn1 < cs[4] ? mn1 : cs[4];
         wire signed [9:0] cf = ctrl_r[`DBP_F_CFULL] ? $signed({cdl[7][7], cdl[7], 1'b0})
                                : cdl[7]; // [RQ16]
         wire signed [9:0] cfp = ctrl_r[`DBP_F_CFULL] ? $signed({cq, 1'b0}) : cq;
         wire signed [10:0] a = cf + 10'sh100;
         wire signed [10:0] b = (cf + cfp + 11'sh200) >>> 1;
         assign d2all[g*12 +: 12] = d2;
         assign smag[g*11 +: 11] = sa;
         assign co0[g*9 +: 9] = o0;
         assign co1[g*9 +: 9] = o1;
         always @(posedge aclk) begin
            cs[0] <= g ? pix_v_in : pix_u_in;
            for (n = 4; n > 0; n = n - 1) begin
               cs[n] <= cs[n-1];
            end
            l0 <= lp;
            l1 <= l0;
            l2 <= l1;
            cdl[0] <= cr > mx ? mx : (cr < mn ? mn : cr[7:0]); // [RQ12]
            for (n = 7; n > 0; n = n - 1) begin
               cdl[n] <= cdl[n-1];
            end
            cq <= cdl[7];
            o0 <= a[10] ? 9'h000 : (a > 11'sh1FF ? 9'h1FF : a[8:0]); // [RQ15]
            o1 <= b[10] ? 9'h000 : (b > 11'sh1FF ? 9'h1FF : b[8:0]);
         end
      end
   endgenerate

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign horiz_sync_out = hs_r;
   assign vert_sync_out = vs_r;
   assign h_active = ha_r;
   assign v_active = va_r;
   assign rd_field_b = fb_r;
   assign rd_prev_field = prev_r;
   assign raster_beta = beta_r;
   assign rd_freeze = frz_r;
   assign dac_y0 = y0_r;
   assign dac_y1 = y1_r;
   assign dac_u0 = co0[8:0];
   assign dac_u1 = co1[8:0];
   assign dac_v0 = co0[17:9];
   assign dac_v1 = co1[17:9];
endmodule // dbp_display_backend

// ==== core/dbp_defs.vh ====
// Register offsets, field positions, reset values and timing counts of the display backend.
`ifndef DBP_DEFS_VH
`define DBP_DEFS_VH
`define DBP_OFF_CTRL 5'h00
`define DBP_OFF_PEAK 5'h04
`define DBP_OFF_HTIM 5'h08
`define DBP_OFF_VTIM 5'h0C
`define DBP_OFF_VMSC 5'h10
`define DBP_OFF_STAT 5'h14
`define DBP_CTRL_RST 32'h00000000
`define DBP_PEAK_RST 32'h08400088
`define DBP_HTIM_RST 32'h0060F120
`define DBP_VTIM_RST 32'h01648138
`define DBP_VMSC_RST 32'h00000002
`define DBP_F_SCS 1:0
`define DBP_F_HOLD 2
`define DBP_F_CSHIFT 3
`define DBP_F_CORBYP 4
`define DBP_F_FINE 5
`define DBP_F_CFULL 6
`define DBP_F_HFR 7
`define DBP_F_VFR 8
`define DBP_F_AUTO 10:9
`define DBP_F_HPOL 11
`define DBP_F_VPOL 12
`define DBP_F_SOFT 13
`define DBP_F_BPG 3:0
`define DBP_F_HPG 7:4
`define DBP_F_CDEL 19:16
`define DBP_F_BOOST 23:20
`define DBP_F_THR 31:24
`define DBP_F_PPLQ 8:0
`define DBP_F_APD16 15:10
`define DBP_F_LEAD 26:16
`define DBP_F_LPFH 9:0
`define DBP_F_ALINES 19:10
`define DBP_F_ILINES 29:20
`define DBP_F_ODEL 3:0
`define DBP_F_SOFF 13:4
`define DBP_HSYNC_LEN 11'h040
`define DBP_VSYNC_LINES 11'h002
`define DBP_CORE_THR 13'h0004
`define DBP_RESP_OK 2'h0
`define DBP_RESP_DEC 2'h3
`endif

// ==== tb/dbp_monitor.sv ====
// Checker for the backend bus handshake and the sync outputs.
`timescale 1ns/10ps
module dbp_monitor (
   input wire aclk, // clock
   input wire aresetn, // reset
   input wire s_axi_awvalid, // aw valid
   input wire s_axi_awready, // aw ready
   input wire s_axi_wvalid, // w valid
   input wire s_axi_wready, // w ready
   input wire s_axi_bvalid, // b valid
   input wire s_axi_bready, // b ready
   input wire [1:0] s_axi_bresp, // b resp
   input wire s_axi_arvalid, // ar valid
   input wire s_axi_arready, // ar ready
   input wire s_axi_rvalid, // r valid
   input wire s_axi_rready, // r ready
   input wire [31:0] s_axi_rdata, // r data
   input wire horiz_sync_out, // hsync
   input wire vert_sync_out, // vsync
   input wire rd_field_b, // field
   input wire raster_beta // raster
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg [7:0] hw_r;
   // Counts consecutive high cycles of the line sync.
   always @(posedge aclk) begin
      hw_r <= (horiz_sync_out && aresetn) ? hw_r + 8'h01 : 8'h00;
   end
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_hsync_width: assert property ($fell(horiz_sync_out) |-> hw_r == 8'h40)
      else $error("line sync width wrong");
   a_field_boundary: assert property ($changed(rd_field_b) || $changed(raster_beta)
      |-> ##[0:1] vert_sync_out) else $error("field choice moved mid field");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property ($rose(vert_sync_out));
endmodule // dbp_monitor
bind dbp_display_backend dbp_monitor dbp_monitor_inst (.*);

// ==== tb/dbp_sync_source.sv ====
// Stand-in for the composite sync separator that feeds the backend.
`timescale 1ns/10ps
module dbp_sync_source (
   input wire aclk, // display clock
   input wire run, // starts the sync pulses
   output reg hsync_in = 1'h0, // line pulse
   output reg vsync_in = 1'h0 // field pulse
);
   reg [15:0] cnt_r = 16'h0000;
   always @(posedge aclk) begin
      cnt_r <= run ? cnt_r + 16'h0001 : 16'h0000;
      hsync_in <= run && cnt_r[7:0] < 8'h10;
      vsync_in <= run && cnt_r[11:0] < 12'h12C;
   end
endmodule // dbp_sync_source

// ==== tb/dbp_display_backend_tb.sv ====
// Self-checking bench for the display backend.
`timescale 1ns/10ps
`include "dbp_defs.vh"
module dbp_display_backend_tb;
   reg aclk = 1'h0;
   reg aresetn = 1'h0;
   reg [7:0] s_axi_awaddr = 8'h00;
   reg [7:0] s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h00000000;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, signal_lost = 1'h0, run = 1'h0;
   reg [7:0] pix_y_in = 8'h64;
   reg [7:0] pix_u_in = 8'hF0;
   reg [7:0] pix_v_in = 8'h00;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire hsync_in, vsync_in, horiz_sync_out, vert_sync_out;
   wire rd_field_b, rd_prev_field, raster_beta, rd_freeze, h_active;
   wire [8:0] dac_y0, dac_y1, dac_u0, dac_v0;
   integer fail_count = 0, num_checks = 0, i, m;
   reg [31:0] d;
   reg [1:0] r;
   reg [2:0] msk;
   dbp_display_backend dbp_display_backend_inst (.*, .v_active(),
      .dac_u1(), .dac_v1());
   dbp_sync_source dbp_sync_source_inst (.aclk(aclk), .run(run),
      .hsync_in(hsync_in), .vsync_in(vsync_in));
   initial forever #50 aclk = ~aclk;
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] v);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         while (s_axi_bvalid !== 1'h1) begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         end
         r = s_axi_bresp;
         s_axi_bready <= 1'h0;
         @(posedge aclk);
      end
   endtask
   task rd(input [7:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         while (s_axi_rvalid !== 1'h1) begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         end
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'h0;
         @(posedge aclk);
      end
   endtask
   // Counts edges while the chosen sync output sits at the given level.
   task span(input h, input lvl);
      begin
         for (i = 0; i < 9000 && (h ? horiz_sync_out : vert_sync_out) === lvl; i = i + 1)
            @(posedge aclk);
         if (i == 9000) fail_count = fail_count + 1;
      end
   endtask
   task wrise(input h);
      begin
         span(h, 1'h1);
         span(h, 1'h0);
      end
   endtask
   task test_done;
      begin
         if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   initial begin
      repeat (80000) @(posedge aclk);
      fail_count = fail_count + 1;
      test_done;
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk(s_axi_awready, 32'h1);
      rd(`DBP_OFF_HTIM);
      chk({d[8:0], 2'h0}, 32'h480);
      chk({d[15:10], 4'h0}, 32'h3C0);
      rd(8'h40);
      chk({d[29:0], r}, `DBP_RESP_DEC);
      wr(8'h40, 32'h00000001);
      chk(r, `DBP_RESP_DEC);
      wr(`DBP_OFF_CTRL, 32'h00000080);
      chk(r, `DBP_RESP_OK);
      run <= 1'h1;
      wr(`DBP_OFF_HTIM, 32'h00102040);
      wrise(1'h0);
      wrise(1'h0);
      wrise(1'h1);
      span(1'h1, 1'h1);
      chk(i, 32'h40);
      span(1'h1, 1'h0);
      chk(i, 32'hC0);
      wrise(1'h0);
      span(1'h0, 1'h1);
      chk(i, 32'h200);
      chk(dac_y0, 32'hE4);
      chk(dac_y1, 32'hE4);
      chk(dac_u0, 32'hF0);
      chk(dac_v0, 32'h100);
      while (h_active === 1'h1) @(posedge aclk);
      while (h_active !== 1'h1) @(posedge aclk);
      for (i = 0; h_active === 1'h1; i = i + 1) @(posedge aclk);
      chk(i, 32'h80);
      for (m = 0; m < 4; m = m + 1) begin
         wr(`DBP_OFF_CTRL, 32'h00000080 | m);
         wrise(1'h0);
         wrise(1'h0);
         repeat (4) @(posedge aclk);
         msk = (m == 0) ? 3'h2 : (m == 1) ? 3'h7 : (m == 2) ? 3'h6 : 3'h5;
         chk({rd_field_b, rd_prev_field, raster_beta} & msk, (m == 3) ? 3'h5 : 3'h0);
      end
      wr(`DBP_OFF_CTRL, 32'h00000084);
      wrise(1'h0);
      wrise(1'h0);
      chk(rd_freeze, 32'h1);
      wr(`DBP_OFF_CTRL, 32'h00000600);
      signal_lost <= 1'h1;
      repeat (20) @(posedge aclk);
      rd(`DBP_OFF_STAT);
      chk(d[10:9], 32'h3);
      test_done;
   end
endmodule // dbp_display_backend_tb
